/* File: src/dic_map.svh */
// Register offsets, field positions and reset values of the input conditioning block
`ifndef DIC_MAP_SVH
`define DIC_MAP_SVH

`define DIC_ADDR_W 8
`define DIC_OFS_IN5_POL 8'h00
`define DIC_OFS_IN5_FUNC 8'h04
`define DIC_OFS_IN6_POL 8'h08
`define DIC_OFS_IN6_FUNC 8'h0c
`define DIC_OFS_STATUS 8'h10
`define DIC_POL_BIT 0
`define DIC_FUNC_BIT 0
`define DIC_EDGE_BIT 4
`define DIC_STAT_LEVEL_LSB 0
`define DIC_STAT_SEEN_LSB 8
`define DIC_CFG_RESET 16'h0000
`define DIC_RESP_OKAY 2'h0
`define DIC_RESP_SLVERR 2'h2

`endif

/* File: src/dic_pkg.sv */
// Types shared by the input conditioning block
package dic_pkg;
  typedef struct packed {
    logic polInv;
    logic latchEn;
    logic edgeFall;
  } dic_cfg_s;

  typedef enum logic [2:0] {
    DIC_REG_NONE = 3'h0,
    DIC_REG_POL = 3'h1,
    DIC_REG_FUNC = 3'h2,
    DIC_REG_STATUS = 3'h4
  } dic_regkind_e;
endpackage

/* File: src/dic_channel.sv */
// One input channel: synchroniser, polarity and latch edge detection
`timescale 1ns/10ps
`default_nettype none
module dic_channel (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin,
  input wire dic_pkg::dic_cfg_s cfg,
  output logic levelQ,
  output logic trigQ
);
  logic syncA_q;
  logic syncB_q;
  logic cond;

  // Two-flop synchroniser on the pin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else if (ce) begin
      syncA_q <= pin;
      syncB_q <= syncA_q;
    end
  end

  assign cond = syncB_q ^ cfg.polInv;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      levelQ <= 1'b0;
    end else if (ce) begin
      levelQ <= cond;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trigQ <= 1'b0;
    end else if (ce) begin
      if (cfg.latchEn) begin
        trigQ <= cfg.edgeFall ? (levelQ & ~cond) : (~levelQ & cond);
      end else begin
        trigQ <= 1'b0;
      end
    end
  end

  a_level_follows_pin: assert property (@(posedge core_clk) disable iff (!rstn)
    ($past(rstn, 3) && $past(ce) && $past(ce, 2) && $past(ce, 3) && $stable(cfg.polInv)) |->
      (levelQ == ($past(pin, 3) ^ cfg.polInv)))
    else $error("level does not follow pin with polarity");

  a_digital_no_trig: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && !cfg.latchEn) |=> !trigQ)
    else $error("trigger in digital input mode");

  a_rise_edge_trig: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && cfg.latchEn && !cfg.edgeFall && !levelQ && cond) |=> trigQ)
    else $error("rising edge trigger missed");

  a_fall_edge_trig: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && cfg.latchEn && cfg.edgeFall && levelQ && !cond) |=> trigQ)
    else $error("falling edge trigger missed");

  a_trig_single_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && trigQ && $stable(cfg)) |=> !trigQ)
    else $error("trigger longer than one cycle");

  a_trig_needs_change: assert property (@(posedge core_clk) disable iff (!rstn)
    ($past(ce) && trigQ) |-> (levelQ != $past(levelQ)))
    else $error("trigger without corrected level change");
endmodule
`default_nettype wire

/* File: src/dic_top.sv */
// Digital input conditioning for two channels with an AXI4-Lite register slave
// Summary of operation
// - Polarity digit: zero passes, one inverts.
// - Function digit: zero digital, one latch.
// - Edge digit: zero rising, one falling.
// - Function digit resets to zero.
// - Edge digit resets to zero.
// - Latch mode pulses trigger on chosen edge.
// - Each channel has its own two words.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dic_map.svh"
module dic_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic inputChannelFive,
  input wire logic inputChannelSix,
  output logic [1:0] condLevel,
  output logic [1:0] latchTrig,
  input wire logic [`DIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic rstMeta_q;
  logic rstSync_q;
  logic [15:0] polCfg_q [2];
  logic [15:0] funcCfg_q [2];
  logic [1:0] latchSeen_q;
  logic [1:0] pins;
  logic awHeld_q;
  logic [`DIC_ADDR_W-1:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wrFire;
  logic [15:0] wrMask;
  logic [2:0] wrKind;
  logic wrCh;
  logic [2:0] rdKind;
  logic rdCh;

  // Register kind of an address: pol, func, status or none
  function automatic logic [2:0] regKind(input logic [`DIC_ADDR_W-1:0] a);
    unique case (a)
      `DIC_OFS_IN5_POL, `DIC_OFS_IN6_POL: regKind = dic_pkg::DIC_REG_POL;
      `DIC_OFS_IN5_FUNC, `DIC_OFS_IN6_FUNC: regKind = dic_pkg::DIC_REG_FUNC;
      `DIC_OFS_STATUS: regKind = dic_pkg::DIC_REG_STATUS;
      default: regKind = dic_pkg::DIC_REG_NONE;
    endcase
  endfunction

  // Channel addressed: six for its two words, five otherwise
  function automatic logic regChan(input logic [`DIC_ADDR_W-1:0] a);
    regChan = (a == `DIC_OFS_IN6_POL) || (a == `DIC_OFS_IN6_FUNC);
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Write address and data taken in either order
  assign s_axi_awready = ce && !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = ce && !wHeld_q && !s_axi_bvalid;
  assign wrFire = ce && awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrKind = regKind(awAddr_q);
  assign wrCh = regChan(awAddr_q);
  assign wrMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DIC_RESP_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrKind == dic_pkg::DIC_REG_NONE) ? `DIC_RESP_SLVERR : `DIC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Setting words and conditioning per channel
  assign pins = {inputChannelSix, inputChannelFive};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gCh
      dic_pkg::dic_cfg_s cfg;

      always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
          polCfg_q[gi] <= `DIC_CFG_RESET;
          funcCfg_q[gi] <= `DIC_CFG_RESET;
        end else if (ce && wrFire && (wrCh == 1'(gi))) begin
          if (wrKind == dic_pkg::DIC_REG_POL) begin
            polCfg_q[gi] <= (polCfg_q[gi] & ~wrMask) | (wData_q[15:0] & wrMask);
          end
          if (wrKind == dic_pkg::DIC_REG_FUNC) begin
            funcCfg_q[gi] <= (funcCfg_q[gi] & ~wrMask) | (wData_q[15:0] & wrMask);
          end
        end
      end

      assign cfg = '{
        polInv: polCfg_q[gi][`DIC_POL_BIT],
        latchEn: funcCfg_q[gi][`DIC_FUNC_BIT],
        edgeFall: funcCfg_q[gi][`DIC_EDGE_BIT]
      };

      dic_channel u_dic_channel (
        .core_clk(core_clk),
        .rstn(rstSync_q),
        .ce(ce),
        .pin(pins[gi]),
        .cfg(cfg),
        .levelQ(condLevel[gi]),
        .trigQ(latchTrig[gi])
      );

      // Sticky trigger record, set wins over a write-one clear
      always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
          latchSeen_q[gi] <= 1'b0;
        end else if (ce) begin
          if (latchTrig[gi]) begin
            latchSeen_q[gi] <= 1'b1;
          end else if (wrFire && wrKind == dic_pkg::DIC_REG_STATUS && wStrb_q[1]
                       && wData_q[`DIC_STAT_SEEN_LSB + gi]) begin
            latchSeen_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Read channel
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign rdKind = regKind(s_axi_araddr);
  assign rdCh = regChan(s_axi_araddr);

  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DIC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DIC_RESP_OKAY;
        unique case (rdKind)
          dic_pkg::DIC_REG_POL: s_axi_rdata <= {16'h0000, polCfg_q[rdCh]};
          dic_pkg::DIC_REG_FUNC: s_axi_rdata <= {16'h0000, funcCfg_q[rdCh]};
          dic_pkg::DIC_REG_STATUS: s_axi_rdata <= {22'h000000, latchSeen_q, 6'h00, condLevel};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DIC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_reset_func_zero: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    !$past(rstSync_q) |->
      (funcCfg_q[0][`DIC_FUNC_BIT] == 1'b0) && (funcCfg_q[1][`DIC_FUNC_BIT] == 1'b0))
    else $error("function digit not zero after reset");

  a_reset_edge_zero: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    !$past(rstSync_q) |->
      (funcCfg_q[0][`DIC_EDGE_BIT] == 1'b0) && (funcCfg_q[1][`DIC_EDGE_BIT] == 1'b0))
    else $error("edge digit not zero after reset");

  a_indep_five_write: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    (wrFire && !wrCh) |=> ($stable(polCfg_q[1]) && $stable(funcCfg_q[1])))
    else $error("write to channel five changed channel six");

  a_indep_six_write: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    (wrFire && wrCh) |=> ($stable(polCfg_q[0]) && $stable(funcCfg_q[0])))
    else $error("write to channel six changed channel five");

  a_func_write_lands: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    (wrFire && wrKind == dic_pkg::DIC_REG_FUNC && wStrb_q[0]) |=>
      (funcCfg_q[$past(wrCh)][7:0] == $past(wData_q[7:0])))
    else $error("function word write lost");

  a_seen_after_trig: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    (ce && latchTrig[0]) |=> latchSeen_q[0])
    else $error("trigger not recorded");

  a_bresp_in_two: assert property (@(posedge core_clk) disable iff (!rstSync_q)
    (ce && awHeld_q && wHeld_q && !s_axi_bvalid) |=> s_axi_bvalid)
    else $error("write response late");
endmodule
`default_nettype wire

/* File: dv/dic_pin_src.sv */
// External signal source driving the two input pins
`timescale 1ns/10ps
`default_nettype none
module dic_pin_src (
  input wire logic [1:0] want,
  input wire logic slow,
  output logic [1:0] pins
);
  // Pins follow the commanded level after a short or long delay
  initial pins = 2'h0;
  always @(want) begin
    if (slow) begin
      pins <= #7 want;
    end else begin
      pins <= #2 want;
    end
  end
endmodule
`default_nettype wire

/* File: dv/dic_top_tb.sv */
// Testbench of the two channel input conditioning block
`timescale 1ns/10ps
`default_nettype none
`include "dic_map.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin failCount++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module dic_top_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] want = 2'h0;
  logic slow = 1'b0, ce = 1'b1;
  logic [1:0] pins, condLevel, latchTrig, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, expSt, seed = 32'hbaa45513;
  logic [3:0] s_axi_wstrb = 4'h0, n, m, strb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ch;
  logic pol[2], lat[2], edg[2];
  int failCount = 0, testsRun = 0, cyc = 0;

  dic_pin_src u_dic_pin_src (.want(want), .slow(slow), .pins(pins));
  dic_top u_dic_top (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .inputChannelFive(pins[0]), .inputChannelSix(pins[1]),
    .condLevel(condLevel), .latchTrig(latchTrig),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Expected levels and trigger count from pin and settings
  function automatic logic [1:0] expLvl();
    return {want[1] ^ pol[1], want[0] ^ pol[0]};
  endfunction

  function automatic logic [3:0] expTrig(input logic c);
    return (lat[c] && ((want[c] ^ pol[c]) != edg[c])) ? 4'h1 : 4'h0;
  endfunction

  task automatic results();
    if (failCount == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic bOk;
    bOk = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bOk) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bOk = s_axi_bvalid;
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic rOk;
    rOk = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rOk) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rOk = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv, rsp);
    `CHK(rdv, e)
    `CHK(rsp, `DIC_RESP_OKAY)
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      results();
    end
  end

  initial begin
    pol = '{1'b0, 1'b0};
    lat = '{1'b0, 1'b0};
    edg = '{1'b0, 1'b0};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 4; k++) cr(8'(4 * k), 32'h0);
    rd(8'h14, rdv, rsp);
    `CHK(rsp, `DIC_RESP_SLVERR)
    `CHK(rdv, 32'h0)
    wr(8'h14, 32'h1, rsp);
    `CHK(rsp, `DIC_RESP_SLVERR)
    // Upper byte strobe only: the low digits must not move
    strb = 4'h2;
    wr(`DIC_OFS_IN6_FUNC, 32'h11, rsp);
    strb = 4'hf;
    cr(`DIC_OFS_IN6_FUNC, 32'h0);
    // Every setting combination on both channels, then random ones
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      ch = (i < 16) ? i[3] : seed[0];
      {edg[ch], lat[ch], pol[ch]} = (i < 16) ? i[2:0] : seed[3:1];
      slow <= seed[5];
      wr(ch ? `DIC_OFS_IN6_POL : `DIC_OFS_IN5_POL, {31'h0, pol[ch]}, rsp);
      wr(ch ? `DIC_OFS_IN6_FUNC : `DIC_OFS_IN5_FUNC, {27'h0, edg[ch], 3'h0, lat[ch]}, rsp);
      cr(ch ? `DIC_OFS_IN6_POL : `DIC_OFS_IN5_POL, {31'h0, pol[ch]});
      cr(ch ? `DIC_OFS_IN6_FUNC : `DIC_OFS_IN5_FUNC, {27'h0, edg[ch], 3'h0, lat[ch]});
      @(posedge core_clk);
      want[ch] <= seed[4];
      repeat (6) @(posedge core_clk);
      `CHK(condLevel, expLvl())
      rd(`DIC_OFS_STATUS, rdv, rsp);
      `CHK(rdv[1:0], expLvl())
      wr(`DIC_OFS_STATUS, 32'h300, rsp);
      `CHK(rsp, `DIC_RESP_OKAY)
      want[ch] <= ~want[ch];
      n = 4'h0;
      m = 4'h0;
      repeat (6) begin
        @(negedge core_clk);
        n = n + 4'(latchTrig[ch]);
        m = m + 4'(latchTrig[~ch]);
      end
      `CHK(n, expTrig(ch))
      `CHK(m, 4'h0)
      `CHK(condLevel, expLvl())
      expSt = 32'(expLvl());
      expSt[8 + ch] = (expTrig(ch) != 4'h0);
      cr(`DIC_OFS_STATUS, expSt);
    end
    // Reset in mid-run after a latch setting, then a clock enable freeze
    wr(`DIC_OFS_IN6_FUNC, 32'h11, rsp);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    pol = '{1'b0, 1'b0};
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 4; k++) cr(8'(4 * k), 32'h0);
    @(posedge core_clk);
    ce <= 1'b0;
    want <= ~want;
    repeat (6) @(posedge core_clk);
    `CHK(condLevel, ~expLvl())
    ce <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(condLevel, expLvl())
    results();
  end
endmodule
`default_nettype wire
